// ===== design/scs_system_clock_control.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - Oscillators also clock watchdog and time base.
// - Four sources: two fast, two slow.
// - Divide select picks fast or slow, live.
// - Low select bit: slow crystal or slow RC.
// - High select bit: fast crystal or fast RC.
// - Divide select also sets system clock frequency.
// - One fast and one slow choice always held.
// - Two-bit field sets fast RC 8/12/16 MHz.
// - Slow crystal enable starts it; wait start-up.
// - Halt stops system clock; timer clocks continue.
// - Slow crystal pins are I/O unless used.
// - Fast source divided by 1 to 64.
// - Fast oscillator enable decides stop in slow mode.
module scs_system_clock_control
#(
    parameter logic [scs_pkg::TIMER_W-1:0] SLOW_START_CYC = scs_pkg::SLOW_XTAL_START_CYC
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fast_xtal_osc,
    input wire logic fast_rc_osc,
    input wire logic slow_xtal_osc,
    input wire logic slow_rc_osc,
    input wire logic halt_req,
    output logic fast_xtal_osc_en,
    output logic fast_rc_osc_en,
    output logic slow_xtal_osc_en,
    output logic [1:0] rc_fast_freq_select,
    output logic slow_xtal_pins_osc_mode,
    output logic sysclk_out,
    output logic fast_periph_clk,
    output logic slow_periph_clk,
    output logic wdt_clk,
    output logic timebase_clk
);
    import scs_pkg::*;

    typedef struct packed
    {
        logic [2:0] div_sel;
        logic high_sel;
        logic low_sel;
        logic fidle;
        logic sidle;
        logic [1:0] rc_freq;
        logic rc_en;
        logic fx_en;
        logic sx_en;
        logic pin_osc;
        scs_sw_t sw;
        logic act_slow;
        logic act_high;
        logic act_low;
        logic [2:0] act_div;
        logic gate;
        logic halted;
        logic waitreq;
        logic [31:0] rdata;
        logic sysclk;
        logic fper;
        logic sper;
        logic wdt;
        logic tb;
        logic fx_oe;
        logic rc_oe;
        logic sx_oe;
        logic pins_osc;
    } scs_state_t;

    localparam scs_state_t ST_RST = '{
        div_sel: DIV_SEL_RST,
        high_sel: HIGH_SEL_RST,
        low_sel: LOW_SEL_RST,
        rc_freq: RC_FREQ_RST,
        sw: SW_WAIT_READY,
        act_div: DIV_SEL_RST,
        act_high: HIGH_SEL_RST,
        act_low: LOW_SEL_RST,
        waitreq: WAITREQ_RST,
        default: '0
    };

    scs_state_t q;
    scs_state_t d;
    logic rc_ready;
    logic fx_ready;
    logic sx_ready;
    logic fast_div;
    logic fast_sel_clk;
    logic fsub;
    logic sel_clk;
    logic t_slow;
    logic t_ready;
    logic changed;
    logic wr_take;
    logic [31:0] rd;

    // Each oscillator except the slow RC is trusted only after its own start-up count; the slow RC is trusted at once.
    scs_ready_timer #(.COUNT(FAST_RC_START_CYC)) u_rc_timer
    (
        .clock(clock),
        .reset_n(reset_n),
        .enable(q.rc_oe),
        .ready(rc_ready)
    );

    scs_ready_timer #(.COUNT(FAST_XTAL_START_CYC)) u_fx_timer
    (
        .clock(clock),
        .reset_n(reset_n),
        .enable(q.fx_oe),
        .ready(fx_ready)
    );

    scs_ready_timer #(.COUNT(SLOW_START_CYC)) u_sx_timer
    (
        .clock(clock),
        .reset_n(reset_n),
        .enable(q.sx_oe),
        .ready(sx_ready)
    );

    // The divider sees only the committed ratio, so a new ratio waits for the gate.
    scs_divider u_divider
    (
        .clock(clock),
        .reset_n(reset_n),
        .src_in(fast_sel_clk),
        .ratio_sel(q.act_div),
        .div_out(fast_div)
    );

    // Source muxes run from the committed selection, never straight from software.
    assign fast_sel_clk = (q.act_high == HIGH_SRC_XTAL) ? fast_xtal_osc : fast_rc_osc;
    assign fsub = (q.act_low == LOW_SRC_XTAL) ? slow_xtal_osc : slow_rc_osc;
    assign sel_clk = q.act_slow ? fsub : fast_div;

    // Both a fast and a slow choice are always held; any difference starts a switch.
    assign t_slow = (q.div_sel == DIV_SLOW);
    assign changed = {t_slow, q.high_sel, q.low_sel, q.div_sel} !=
                     {q.act_slow, q.act_high, q.act_low, q.act_div};
    assign t_ready = t_slow ? ((q.low_sel == LOW_SRC_XTAL) ? sx_ready : 1'b1)
                            : ((q.high_sel == HIGH_SRC_XTAL) ? fx_ready : rc_ready);

    assign wr_take = avs_write && !q.waitreq && avs_byteenable[0];

    // Read view; unmapped offsets read as zero.
    always_comb
    begin
        rd = '0;
        case (avs_address)
            REG_CLK_CTRL:
            begin
                rd[CC_DIV_LSB +: 3] = q.div_sel;
                rd[CC_HIGH_BIT] = q.high_sel;
                rd[CC_LOW_BIT] = q.low_sel;
                rd[CC_FIDLE_BIT] = q.fidle;
                rd[CC_SIDLE_BIT] = q.sidle;
            end
            REG_RC_CTRL:
            begin
                rd[RC_FREQ_LSB +: 2] = q.rc_freq;
                rd[RC_READY_BIT] = rc_ready;
                rd[RC_EN_BIT] = q.rc_en;
            end
            REG_XTAL_CTRL:
            begin
                rd[XC_SLOW_EN_BIT] = q.sx_en;
                rd[XC_SLOW_RDY_BIT] = sx_ready;
                rd[XC_FAST_EN_BIT] = q.fx_en;
                rd[XC_FAST_RDY_BIT] = fx_ready;
                rd[XC_PIN_OSC_BIT] = q.pin_osc;
            end
            REG_STATUS:
            begin
                rd[ST_SLOW_BIT] = q.act_slow;
                rd[ST_BUSY_BIT] = (q.sw != SW_RUN);
                rd[ST_HALT_BIT] = q.halted;
                rd[ST_HIGH_BIT] = q.act_high;
                rd[ST_LOW_BIT] = q.act_low;
            end
            default:
                rd = '0;
        endcase
    end

    // Next state: bus slave, register writes, switch sequencer and clock outputs.
    always_comb
    begin
        d = q;
        // Every access is answered one cycle after it is seen, then waitrequest rises again.
        if (!q.waitreq)
            d.waitreq = 1'b1;
        else if (avs_read || avs_write)
        begin
            d.waitreq = 1'b0;
            d.rdata = rd;
        end
        if (wr_take)
        begin
            case (avs_address)
                REG_CLK_CTRL:
                begin
                    d.div_sel = avs_writedata[CC_DIV_LSB +: 3];
                    d.high_sel = avs_writedata[CC_HIGH_BIT];
                    d.low_sel = avs_writedata[CC_LOW_BIT];
                    d.fidle = avs_writedata[CC_FIDLE_BIT];
                    d.sidle = avs_writedata[CC_SIDLE_BIT];
                end
                REG_RC_CTRL:
                begin
                    d.rc_freq = avs_writedata[RC_FREQ_LSB +: 2];
                    d.rc_en = avs_writedata[RC_EN_BIT];
                end
                REG_XTAL_CTRL:
                begin
                    d.sx_en = avs_writedata[XC_SLOW_EN_BIT];
                    d.fx_en = avs_writedata[XC_FAST_EN_BIT];
                    d.pin_osc = avs_writedata[XC_PIN_OSC_BIT];
                end
                default:
                    d.pin_osc = q.pin_osc;
            endcase
        end
        // Close the gate only while the old clock is low and open it only while the
        // new one is low, so no shortened pulse ever reaches the system clock.
        unique case (q.sw)
            SW_RUN:
                if (changed)
                    d.sw = SW_WAIT_READY;
            SW_WAIT_READY:
                if (t_ready)
                    d.sw = SW_WAIT_OLD_LOW;
            SW_WAIT_OLD_LOW:
                if (!t_ready)
                    d.sw = SW_WAIT_READY;
                else if (!sel_clk)
                begin
                    d.gate = 1'b0;
                    d.act_slow = t_slow;
                    d.act_high = q.high_sel;
                    d.act_low = q.low_sel;
                    d.act_div = q.div_sel;
                    d.sw = SW_WAIT_NEW_LOW;
                end
            SW_WAIT_NEW_LOW:
                if (!sel_clk)
                begin
                    d.gate = 1'b1;
                    d.sw = SW_RUN;
                end
        endcase
        // Halt takes hold and lets go only on a low phase of the selected clock.
        if (!sel_clk)
            d.halted = halt_req;
        d.sysclk = d.gate && !d.halted && sel_clk;
        d.fper = fast_sel_clk && (!d.halted || q.fidle);
        d.sper = fsub && (!d.halted || q.sidle);
        d.wdt = slow_rc_osc;
        d.tb = fsub;
        // A fast oscillator runs while selected or targeted, otherwise only on its enable.
        d.fx_oe = q.fx_en || (!q.act_slow && q.act_high == HIGH_SRC_XTAL)
                  || (!t_slow && q.high_sel == HIGH_SRC_XTAL);
        d.rc_oe = q.rc_en || (!q.act_slow && q.act_high == HIGH_SRC_RC)
                  || (!t_slow && q.high_sel == HIGH_SRC_RC);
        d.sx_oe = q.sx_en || (q.act_low == LOW_SRC_XTAL);
        // Pins leave I/O use as soon as the slow crystal can be a clock source.
        d.pins_osc = q.pin_osc || d.sx_oe;
    end

    // State register.
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            q <= ST_RST;
        else
            q <= d;
    end

    // All outputs come straight from the state register.
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign fast_xtal_osc_en = q.fx_oe;
    assign fast_rc_osc_en = q.rc_oe;
    assign slow_xtal_osc_en = q.sx_oe;
    assign rc_fast_freq_select = q.rc_freq;
    assign slow_xtal_pins_osc_mode = q.pins_osc;
    assign sysclk_out = q.sysclk;
    assign fast_periph_clk = q.fper;
    assign slow_periph_clk = q.sper;
    assign wdt_clk = q.wdt;
    assign timebase_clk = q.tb;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_commit;
        q.sw == SW_WAIT_OLD_LOW && t_ready && !sel_clk;
    endsequence

    a_bus_answer: assert property ((avs_read || avs_write) && q.waitreq |=> !avs_waitrequest)
        else $error("access not answered in one cycle");
    a_slow_start: assert property ($rose(q.sx_oe) |-> !sx_ready [*8])
        else $error("slow crystal ready without start-up delay");
    a_run_leave: assert property ((q.sw == SW_RUN && changed) |=> q.sw == SW_WAIT_READY)
        else $error("selection change not picked up");
    a_switch_gate: assert property (s_commit |=> q.sw == SW_WAIT_NEW_LOW && !q.gate && !sysclk_out)
        else $error("switch commit did not close gate");
    a_gate_open: assert property ($rose(q.gate) |-> !sysclk_out)
        else $error("gate opened on a high phase");
    a_div_apply: assert property (s_commit |=> q.act_div == $past(q.div_sel))
        else $error("new divide select not committed");
    a_fast_src: assert property ((q.sw == SW_RUN && !q.act_slow && q.act_high) |-> fast_xtal_osc_en)
        else $error("fast crystal selected but stopped");
    a_slow_src: assert property ((q.sw == SW_RUN && q.act_slow && q.act_low) |-> slow_xtal_osc_en)
        else $error("slow crystal selected but stopped");
    a_fast_stop: assert property ((q.sw == SW_RUN && q.act_slow && !changed && !q.fx_en && !q.rc_en)
        |=> !fast_xtal_osc_en && !fast_rc_osc_en)
        else $error("fast oscillator kept running in slow mode");
    a_halt_stops: assert property (q.halted |-> !sysclk_out)
        else $error("system clock ran while halted");
    a_pins_osc: assert property (slow_xtal_osc_en |-> slow_xtal_pins_osc_mode)
        else $error("slow crystal pins left as I/O while in use");
    a_rc_freq: assert property ((wr_take && avs_address == REG_RC_CTRL)
        |=> rc_fast_freq_select == $past(avs_writedata[3:2]))
        else $error("fast RC frequency not updated");
    a_wdt_clock: assert property (1'b1 |=> wdt_clk == $past(slow_rc_osc))
        else $error("watchdog clock does not follow slow RC");

endmodule // scs_system_clock_control

// ===== design/scs_pkg.sv
package scs_pkg;

    // Register byte offsets on the Avalon-MM slave, one aligned word each.
    localparam logic [3:0] REG_CLK_CTRL = 4'h0;
    localparam logic [3:0] REG_RC_CTRL = 4'h4;
    localparam logic [3:0] REG_XTAL_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // Clock control register fields.
    localparam int CC_DIV_LSB = 5;
    localparam int CC_HIGH_BIT = 3;
    localparam int CC_LOW_BIT = 2;
    localparam int CC_FIDLE_BIT = 1;
    localparam int CC_SIDLE_BIT = 0;

    // Fast RC control register fields.
    localparam int RC_FREQ_LSB = 2;
    localparam int RC_READY_BIT = 1;
    localparam int RC_EN_BIT = 0;

    // Crystal control register fields.
    localparam int XC_SLOW_EN_BIT = 0;
    localparam int XC_SLOW_RDY_BIT = 1;
    localparam int XC_FAST_EN_BIT = 2;
    localparam int XC_FAST_RDY_BIT = 3;
    localparam int XC_PIN_OSC_BIT = 4;

    // Status register fields.
    localparam int ST_SLOW_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_HALT_BIT = 2;
    localparam int ST_HIGH_BIT = 3;
    localparam int ST_LOW_BIT = 4;

    // Divide select code that picks the slow source instead of the fast one.
    localparam logic [2:0] DIV_SLOW = 3'h7;

    // Source select and fast RC frequency encodings.
    localparam logic HIGH_SRC_RC = 1'b0;
    localparam logic HIGH_SRC_XTAL = 1'b1;
    localparam logic LOW_SRC_RC = 1'b0;
    localparam logic LOW_SRC_XTAL = 1'b1;
    localparam logic [1:0] RC_8MHZ = 2'h0;
    localparam logic [1:0] RC_12MHZ = 2'h1;
    localparam logic [1:0] RC_16MHZ = 2'h2;

    // Nominal source frequencies, for reference by users of the block.
    localparam int FAST_XTAL_MIN_KHZ = 400;
    localparam int FAST_XTAL_MAX_KHZ = 16000;
    localparam int SLOW_XTAL_HZ = 32768;
    localparam int SLOW_RC_HZ = 32000;

    // Values after reset.
    localparam logic [2:0] DIV_SEL_RST = 3'h0;
    localparam logic HIGH_SEL_RST = HIGH_SRC_RC;
    localparam logic LOW_SEL_RST = LOW_SRC_RC;
    localparam logic [1:0] RC_FREQ_RST = RC_8MHZ;
    localparam logic WAITREQ_RST = 1'b1;

    // Start-up times and their cycle counts at the 125 MHz clock.
    localparam int TIMER_W = 20;
    localparam int CLK_MHZ = 125;
    localparam int SLOW_XTAL_START_US = 1000;
    localparam int FAST_XTAL_START_US = 32;
    localparam int FAST_RC_START_NS = 100;
    localparam logic [TIMER_W-1:0] SLOW_XTAL_START_CYC = TIMER_W'(SLOW_XTAL_START_US * CLK_MHZ);
    localparam logic [TIMER_W-1:0] FAST_XTAL_START_CYC = TIMER_W'(FAST_XTAL_START_US * CLK_MHZ);
    localparam logic [TIMER_W-1:0] FAST_RC_START_CYC =
        TIMER_W'((FAST_RC_START_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIMER_W-1:0] TMR_ONE = 20'h00001;

    // Source switch sequencer states.
    typedef enum logic [1:0]
    {
        SW_RUN = 2'b00,
        SW_WAIT_READY = 2'b01,
        SW_WAIT_OLD_LOW = 2'b10,
        SW_WAIT_NEW_LOW = 2'b11
    } scs_sw_t;

endpackage

// ===== design/scs_ready_timer.sv
`timescale 1ns/1ns
module scs_ready_timer
#(
    parameter logic [scs_pkg::TIMER_W-1:0] COUNT = scs_pkg::TMR_ONE
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic enable,
    output logic ready
);
    import scs_pkg::*;

    typedef struct packed
    {
        logic [TIMER_W-1:0] cnt;
        logic ready;
    } scs_tmr_t;

    scs_tmr_t q;
    scs_tmr_t d;

    // Count enabled cycles; an oscillator is trusted only after the full count.
    always_comb
    begin
        d = q;
        if (!enable)
        begin
            d.cnt = '0;
            d.ready = 1'b0;
        end
        else if (!q.ready)
        begin
            if (q.cnt == COUNT - TMR_ONE)
                d.ready = 1'b1;
            else
                d.cnt = q.cnt + TMR_ONE;
        end
    end

    // State register.
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end

    assign ready = q.ready;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Readiness is lost at once when the oscillator is switched off.
    a_ready_drops: assert property (!enable |=> !ready)
        else $error("ready stayed high after disable");

    // Readiness only ever comes up while the oscillator is enabled.
    a_ready_cause: assert property ($rose(ready) |-> $past(enable))
        else $error("ready rose without enable");

endmodule // scs_ready_timer

// ===== design/scs_divider.sv
`timescale 1ns/1ns
module scs_divider
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic src_in,
    input wire logic [2:0] ratio_sel,
    output logic div_out
);
    import scs_pkg::*;

    typedef struct packed
    {
        logic src_d;
        logic [5:0] cnt;
        logic out;
    } scs_div_t;

    scs_div_t q;
    scs_div_t d;

    // Ripple-free binary divider: counter bit k halves the source k+1 times.
    always_comb
    begin
        d = q;
        d.src_d = src_in;
        if (src_in && !q.src_d)
            d.cnt = q.cnt + 6'h01;
        unique case (ratio_sel)
            3'h0: d.out = src_in;
            3'h1: d.out = q.cnt[0];
            3'h2: d.out = q.cnt[1];
            3'h3: d.out = q.cnt[2];
            3'h4: d.out = q.cnt[3];
            3'h5: d.out = q.cnt[4];
            3'h6: d.out = q.cnt[5];
            3'h7: d.out = q.cnt[5];
        endcase
    end

    // State register.
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end

    assign div_out = q.out;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Each source rising edge advances the divider chain by one.
    a_count_step: assert property ((src_in && !q.src_d) |=> q.cnt == $past(q.cnt) + 6'h01)
        else $error("divider did not count a source edge");

    // A ratio of one passes the source straight through.
    a_ratio_one: assert property ((ratio_sel == 3'h0) |=> div_out == $past(src_in))
        else $error("ratio one output differs from source");

endmodule // scs_divider

// ===== verification/scs_system_clock_control_tb.sv
`timescale 1ns/1ns
module scs_system_clock_control_tb;
    import scs_pkg::*;
    logic clock, reset_n, avs_read, avs_write, halt_req, fx, frc, sx, sr;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, seed, v;
    logic avs_waitrequest, fx_en, frc_en, sx_en, pins, sys, fper, sper, wdt, tbc;
    logic [1:0] rcf;
    int error_cnt, cmp_count, cnt;
    int tg[5];
    logic [3:0] ra[3] = '{REG_CLK_CTRL, REG_RC_CTRL, REG_XTAL_CTRL};
    logic [7:0] rm[3] = '{8'hEF, 8'h0D, 8'h15};

    // Slow crystal start-up is shortened so the run stays short.
    scs_system_clock_control #(.SLOW_START_CYC(20'h00014)) i_dut
    (
        .clock(clock),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .fast_xtal_osc(fx),
        .fast_rc_osc(frc),
        .slow_xtal_osc(sx),
        .slow_rc_osc(sr),
        .halt_req(halt_req),
        .fast_xtal_osc_en(fx_en),
        .fast_rc_osc_en(frc_en),
        .slow_xtal_osc_en(sx_en),
        .rc_fast_freq_select(rcf),
        .slow_xtal_pins_osc_mode(pins),
        .sysclk_out(sys),
        .fast_periph_clk(fper),
        .slow_periph_clk(sper),
        .wdt_clk(wdt),
        .timebase_clk(tbc)
    );

    // Free-running system clock.
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Oscillator levels; each period differs so a wrong source shows in the toggle count.
    always @(posedge clock)
    begin
        cnt <= cnt + 1;
        frc <= cnt[1];
        fx <= 1'((cnt / 3) % 2);
        sx <= 1'((cnt / 10) % 2);
        sr <= 1'((cnt / 12) % 2);
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected toggles of a square wave with the given half period in bench cycles.
    function automatic int toggles(input int n, input int half);
        return n / half;
    endfunction

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask

    // Toggle counts drift by a cycle or two with divider phase, hence the tolerance.
    task automatic near(input string nm, input int exp, input int tol, input int got);
        cmp_count++;
        if (got < exp - tol || got > exp + tol)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0d, seen %0d", nm, exp, got);
        end
    endtask

    // One Avalon-MM access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            $display("unexpected bus wait: expected answer, seen none");
            summarize();
        end
    endtask

    // Polls the busy flag; a switch that never ends is a failure.
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge clock);
        do
        begin
            bus(1'b0, REG_STATUS, 32'h0, 4'hF);
            n++;
        end
        while (rd[ST_BUSY_BIT] !== 1'b0 && n < 3000);
        if (n >= 3000)
        begin
            error_cnt++;
            $display("unexpected switch busy: expected 0, seen 1");
            summarize();
        end
    endtask

    // Counts toggles of sysclk, wdt, time base, fast and slow peripheral clocks.
    task automatic measure(input int n);
        logic [4:0] p, c;
        tg = '{default: 0};
        @(posedge clock);
        #1 p = {sys, wdt, tbc, fper, sper};
        repeat (n)
        begin
            @(posedge clock);
            #1 c = {sys, wdt, tbc, fper, sper};
            for (int i = 0; i < 5; i++)
                tg[i] += int'(c[i] !== p[i]);
            p = c;
        end
        // Hand back on a rising edge so the caller's next stimulus lands on it.
        @(posedge clock);
    endtask

    // Main sequence.
    initial
    begin
        {reset_n, avs_read, avs_write, halt_req} = '0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        seed = 32'h6BD2A7DE;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        wait_idle();
        bus(1'b0, REG_CLK_CTRL, 32'h0, 4'hF);
        chk("clk_ctrl reset", 32'h0, rd);
        bus(1'b0, REG_XTAL_CTRL, 32'h0, 4'hF);
        chk("xtal_ctrl reset", 32'h0, rd);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF);
        chk("status reset", 32'h0, rd & 32'h1D);
        // Random write and read back of every writable field.
        for (int i = 0; i < 18; i++)
        begin
            seed = xs(seed);
            v = {24'h0, seed[7:0]};
            bus(1'b1, ra[i % 3], v, 4'hF);
            bus(1'b0, ra[i % 3], 32'h0, 4'hF);
            chk("reg readback", v & {24'h0, rm[i % 3]}, rd & {24'hFFFFFF, rm[i % 3]});
        end
        bus(1'b1, REG_CLK_CTRL, 32'h0, 4'hF);
        wait_idle();
        bus(1'b1, REG_XTAL_CTRL, 32'h0, 4'hF);
        bus(1'b1, REG_RC_CTRL, 32'h4, 4'hF);
        bus(1'b1, REG_RC_CTRL, 32'h8, 4'hE);
        bus(1'b0, REG_RC_CTRL, 32'h0, 4'hF);
        chk("masked write", 32'h4, rd & 32'hD);
        bus(1'b1, 4'h2, 32'hFF, 4'hF);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk("unmapped read", 32'h0, rd);
        // Every fast RC frequency code reaches the oscillator.
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, REG_RC_CTRL, 32'(c << 2), 4'hF);
            repeat (3) @(posedge clock);
            chk("rc_fast_freq_select", 32'(c), {30'h0, rcf});
        end
        // Fast RC through each ratio; it toggles every two cycles undivided.
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, REG_CLK_CTRL, 32'(k << 5), 4'hF);
            wait_idle();
            measure(512);
            near("sysclk fast", toggles(512, 2 << k), 2, tg[4]);
        end
        // Slow RC as system clock; the fast RC may stop without its keep bit.
        bus(1'b1, REG_RC_CTRL, 32'h0, 4'hF);
        bus(1'b1, REG_CLK_CTRL, 32'hE0, 4'hF);
        wait_idle();
        chk("status slow", 32'h1, rd & 32'h1D);
        measure(512);
        near("sysclk slow rc", toggles(512, 12), 2, tg[4]);
        near("wdt", toggles(512, 12), 2, tg[3]);
        near("time base", toggles(512, 12), 2, tg[2]);
        chk("fast rc en", 32'h0, {31'h0, frc_en});
        bus(1'b1, REG_RC_CTRL, 32'h1, 4'hF);
        repeat (3) @(posedge clock);
        chk("fast rc keep", 32'h1, {31'h0, frc_en});
        // Slow crystal not enabled: the switch must wait.
        bus(1'b1, REG_CLK_CTRL, 32'hE4, 4'hF);
        repeat (100) @(posedge clock);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF);
        chk("busy w/o enable", 32'h1, {31'h0, rd[ST_BUSY_BIT]});
        bus(1'b1, REG_XTAL_CTRL, 32'h1, 4'hF);
        wait_idle();
        chk("status slow xtal", 32'h11, rd & 32'h1D);
        chk("slow xtal en", 32'h1, {31'h0, sx_en});
        chk("pins osc", 32'h1, {31'h0, pins});
        measure(512);
        near("sysclk slow xtal", toggles(512, 10), 2, tg[4]);
        near("time base xtal", toggles(512, 10), 2, tg[2]);
        // Halt with peripheral clocks off, then on.
        halt_req <= 1'b1;
        repeat (40) @(posedge clock);
        measure(256);
        chk("sysclk halted", 32'h0, 32'(tg[4]));
        chk("fast periph off", 32'h0, 32'(tg[1]));
        chk("slow periph off", 32'h0, 32'(tg[0]));
        near("wdt halted", toggles(256, 12), 2, tg[3]);
        bus(1'b0, REG_STATUS, 32'h0, 4'hF);
        chk("status halted", 32'h1, {31'h0, rd[ST_HALT_BIT]});
        bus(1'b1, REG_CLK_CTRL, 32'hE7, 4'hF);
        repeat (4) @(posedge clock);
        measure(256);
        chk("sysclk halted idle", 32'h0, 32'(tg[4]));
        near("fast periph on", toggles(256, 2), 2, tg[1]);
        near("slow periph on", toggles(256, 10), 2, tg[0]);
        halt_req <= 1'b0;
        repeat (40) @(posedge clock);
        measure(256);
        near("sysclk resumed", toggles(256, 10), 2, tg[4]);
        // Pins return to I/O once the crystal is unused, unless forced.
        bus(1'b1, REG_CLK_CTRL, 32'hE0, 4'hF);
        wait_idle();
        bus(1'b1, REG_XTAL_CTRL, 32'h0, 4'hF);
        repeat (3) @(posedge clock);
        chk("pins io", 32'h0, {31'h0, pins});
        bus(1'b1, REG_XTAL_CTRL, 32'h10, 4'hF);
        repeat (3) @(posedge clock);
        chk("pins forced", 32'h1, {31'h0, pins});
        // Fast crystal at ratio 1.
        bus(1'b1, REG_CLK_CTRL, 32'h08, 4'hF);
        wait_idle();
        chk("status high xtal", 32'h8, rd & 32'h1D);
        chk("fast xtal en", 32'h1, {31'h0, fx_en});
        measure(512);
        near("sysclk fast xtal", toggles(512, 3), 2, tg[4]);
        summarize();
    end
endmodule // scs_system_clock_control_tb
